//--- logic/bmc_mode_control.sv
// Mode-control register logic of a step-down converter.
// Assumes the I2C slave drives writes and read addresses on MCLK.
//
// How it works
// - Converter runs while converter_on is 1 and no soft-start fault has tripped, shut down while 0.
// - force bit 0 lets load pick PFM or PWM; 1 forces PWM.
// - limit_freeze 1 locks floor, ceiling voltage and current limits.
// - softstart_watch 1 starts a 2 ms timer on enable; fault if unregulated.
// - softstart_watch 0 never declares a timeout fault.
// - voltage_ramp_on 1 ramps the target at the rate in bits 2:0.
// - voltage_ramp_on 0 means no dynamic voltage scaling.
// - Rate codes 000..111 map to 0.5 up to 10 mV/us.
`timescale 1ns/10ps
module bmc_mode_control #(
    parameter int SS_CYCLES = bmc_pkg::SS_TIMEOUT_CYCLES
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Register access from the I2C slave
    input wire bmc_pkg::bmc_wr_type REG_WR,
    input wire logic [7:0] REG_RD_ADDR,
    output logic [7:0] REG_RD_DATA,
    // Converter core status (analogue, asynchronous)
    input wire logic IN_REGULATION,
    input wire logic LOAD_HEAVY,
    // Converter core controls
    output bmc_pkg::bmc_core_type CORE_CTRL,
    output logic CONV_RUN,
    output logic PWM_SELECT,
    output logic SS_FAULT,
    output logic [7:0] VOUT_TARGET,
    output logic [7:0] FLOOR_LIMIT,
    output logic [7:0] CEIL_LIMIT,
    output logic [7:0] PFM_ILIMIT,
    output logic [7:0] PWM_ILIMIT
);
    import bmc_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    // Cycles per 10 mV code step for each rate code
    function automatic logic [15:0] step_cycles(input logic [2:0] rate);
        int uv_per_us10;
        uv_per_us10 = 5;
        case (rate)
            3'd0: uv_per_us10 = 5;
            3'd1: uv_per_us10 = 10;
            3'd2: uv_per_us10 = 15;
            3'd3: uv_per_us10 = 20;
            3'd4: uv_per_us10 = 25;
            3'd5: uv_per_us10 = 35;
            3'd6: uv_per_us10 = 50;
            default: uv_per_us10 = 100;
        endcase
        // step_uV / (rate mV/us) in us, times MHz
        step_cycles = 16'((VOUT_STEP_UV / 100 * CLK_MHZ) / uv_per_us10);
    endfunction

    function automatic logic wr_hit(input bmc_wr_type w, input logic [7:0] a);
        wr_hit = w.we && (w.addr == a);
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] reg_sync, load_sync;
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            reg_sync <= 2'b00;
            load_sync <= 2'b00;
        end else begin
            reg_sync <= {reg_sync[0], IN_REGULATION};
            load_sync <= {load_sync[0], LOAD_HEAVY};
        end
    end
    wire in_reg = reg_sync[1];
    wire heavy = load_sync[1];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mode, vsel;
    logic [7:0] limits [4];
    logic [7:0] next_mode, next_vsel;
    logic [7:0] next_limits [4];
    always_comb begin
        next_mode = mode;
        next_vsel = vsel;
        for (int i = 0; i < 4; i++) begin
            next_limits[i] = limits[i];
            // Locked limits ignore host writes until reset
            if (!mode[BIT_LIMIT_FREEZE] &&
                wr_hit(REG_WR, 8'(LIMIT_OFFSET_LO + 8'(i)))) begin
                next_limits[i] = REG_WR.data;
            end
        end
        if (wr_hit(REG_WR, MODE_CTRL_OFFSET)) begin
            next_mode = REG_WR.data;
            // Freeze is sticky until reset
            if (mode[BIT_LIMIT_FREEZE])
                next_mode[BIT_LIMIT_FREEZE] = 1'b1;
        end
        if (wr_hit(REG_WR, VOUT_SEL_OFFSET))
            next_vsel = REG_WR.data;
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode <= MODE_CTRL_RESET;
            vsel <= VOUT_RESET;
            for (int i = 0; i < 4; i++)
                limits[i] <= LIMIT_RESET;
        end else begin
            mode <= next_mode;
            vsel <= next_vsel;
            limits <= next_limits;
        end
    end

    // ------------------------------------------------------------
    // Soft-start watchdog
    // ------------------------------------------------------------
    bmc_ss_type ss_state, next_ss_state;
    logic [31:0] ss_cnt, next_ss_cnt;
    always_comb begin
        next_ss_state = ss_state;
        next_ss_cnt = ss_cnt;
        if (!mode[BIT_CONV_ON]) begin
            next_ss_state = SS_IDLE;
            next_ss_cnt = '0;
        end else begin
            case (ss_state)
                SS_IDLE: begin
                    next_ss_cnt = '0;
                    next_ss_state = SS_WAIT;
                end
                SS_WAIT: begin
                    if (in_reg) begin
                        next_ss_state = SS_GOOD;
                    end else if (mode[BIT_SS_WATCH] &&
                                 ss_cnt >= 32'(SS_CYCLES - 1)) begin
                        next_ss_state = SS_TRIPPED;
                    end else if (mode[BIT_SS_WATCH]) begin
                        next_ss_cnt = ss_cnt + 32'd1;
                    end
                    // Watch off: keep trying forever, no fault
                end
                SS_GOOD: next_ss_state = SS_GOOD;
                SS_TRIPPED: next_ss_state = SS_TRIPPED;
                default: next_ss_state = SS_IDLE;
            endcase
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ss_state <= SS_IDLE;
            ss_cnt <= '0;
        end else begin
            ss_state <= next_ss_state;
            ss_cnt <= next_ss_cnt;
        end
    end

    // ------------------------------------------------------------
    // Voltage ramp
    // ------------------------------------------------------------
    logic [7:0] target, next_target;
    logic [15:0] pace, next_pace;
    always_comb begin
        next_target = target;
        next_pace = pace;
        if (!mode[BIT_RAMP_ON]) begin
            next_target = vsel;
            next_pace = '0;
        end else if (target != vsel) begin
            if (pace >= step_cycles(mode[RAMP_RATE_MSB:0]) - 16'd1) begin
                next_pace = '0;
                next_target = (target < vsel) ? target + 8'd1 : target - 8'd1;
            end else begin
                next_pace = pace + 16'd1;
            end
        end else begin
            next_pace = '0;
        end
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            target <= VOUT_RESET;
            pace <= '0;
        end else begin
            target <= next_target;
            pace <= next_pace;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [7:0] next_rd;
    always_comb begin
        next_rd = 8'h00;
        if (REG_RD_ADDR == MODE_CTRL_OFFSET)
            next_rd = mode;
        else if (REG_RD_ADDR == VOUT_SEL_OFFSET)
            next_rd = vsel;
        else if (REG_RD_ADDR >= LIMIT_OFFSET_LO && REG_RD_ADDR <= LIMIT_OFFSET_HI)
            next_rd = limits[2'(REG_RD_ADDR - LIMIT_OFFSET_LO)];
    end
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RD_DATA <= 8'h00;
            CORE_CTRL <= '0;
            CONV_RUN <= 1'b0;
            PWM_SELECT <= 1'b0;
            SS_FAULT <= 1'b0;
            VOUT_TARGET <= VOUT_RESET;
            FLOOR_LIMIT <= LIMIT_RESET;
            CEIL_LIMIT <= LIMIT_RESET;
            PFM_ILIMIT <= LIMIT_RESET;
            PWM_ILIMIT <= LIMIT_RESET;
        end else begin
            REG_RD_DATA <= next_rd;
            CORE_CTRL <= '{mode[BIT_CONV_ON], mode[BIT_FORCE_PWM], mode[BIT_LIMIT_FREEZE],
                           mode[BIT_RAMP_ON], mode[RAMP_RATE_MSB:0]};
            CONV_RUN <= mode[BIT_CONV_ON] && ss_state != SS_TRIPPED;
            PWM_SELECT <= mode[BIT_FORCE_PWM] || heavy;
            SS_FAULT <= ss_state == SS_TRIPPED;
            VOUT_TARGET <= target;
            FLOOR_LIMIT <= limits[0];
            CEIL_LIMIT <= limits[1];
            PFM_ILIMIT <= limits[2];
            PWM_ILIMIT <= limits[3];
        end
    end
endmodule

//--- logic/bmc_pkg.sv
// Constants and carrier types for the converter mode-control block.
// Assumes the I2C slave presents decoded register writes and reads.
package bmc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_OFFSET = 8'h03;
    localparam logic [7:0] VOUT_SEL_OFFSET = 8'h04;
    localparam logic [7:0] LIMIT_OFFSET_LO = 8'h05;
    localparam logic [7:0] LIMIT_OFFSET_HI = 8'h08;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h1f;
    localparam logic [7:0] VOUT_RESET = 8'hAF;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam int BIT_CONV_ON = 7;
    localparam int BIT_FORCE_PWM = 6;
    localparam int BIT_LIMIT_FREEZE = 5;
    localparam int BIT_SS_WATCH = 4;
    localparam int BIT_RAMP_ON = 3;
    localparam int RAMP_RATE_MSB = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int SS_TIMEOUT_US = 2000;
    localparam int SS_TIMEOUT_CYCLES = SS_TIMEOUT_US * CLK_MHZ;
    // Output step per VOUT code, in microvolts
    localparam int VOUT_STEP_UV = 10000;

    // Register write strobe with address and data
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } bmc_wr_type;

    // Settings presented to the converter core
    typedef struct packed {
        logic conv_on;
        logic force_pwm;
        logic limit_freeze;
        logic ramp_on;
        logic [2:0] ramp_rate;
    } bmc_core_type;

    // Soft-start watch states; the trip state is named apart from the fault port
    typedef enum logic [1:0] {SS_IDLE, SS_WAIT, SS_GOOD, SS_TRIPPED} bmc_ss_type;
endpackage

//--- verification/bmc_host_model.sv
// Host model that writes and reads the converter registers.
// Assumes the block samples requests on the rising MCLK edge.
`timescale 1ns/10ps
module bmc_host_model (
    // Clock
    input wire logic MCLK,
    // Register access
    output bmc_pkg::bmc_wr_type REG_WR,
    output logic [7:0] REG_RD_ADDR,
    input wire logic [7:0] REG_RD_DATA
);
    import bmc_pkg::*;
    // Idle bus at time zero
    initial begin
        REG_WR = '0;
        REG_RD_ADDR = 8'h00;
    end
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_WR <= '{we: 1'b1, addr: a, data: d};
        @(posedge MCLK);
        REG_WR.we <= 1'b0;
    endtask
    // Address held, data taken two edges later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        REG_RD_ADDR <= a;
        repeat (2) @(posedge MCLK);
        d = REG_RD_DATA;
    endtask
endmodule

//--- verification/bmc_monitor.sv
// Port checker for the converter mode-control block.
// Assumes it is bound onto bmc_mode_control.
`timescale 1ns/10ps
module bmc_monitor (
    // Clock, reset, writes
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire bmc_pkg::bmc_wr_type REG_WR,
    // Core outputs
    input wire bmc_pkg::bmc_core_type CORE_CTRL,
    input wire logic CONV_RUN,
    input wire logic PWM_SELECT,
    input wire logic SS_FAULT,
    input wire logic [7:0] VOUT_TARGET,
    input wire logic [7:0] FLOOR_LIMIT
);
    import bmc_pkg::*;
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    // Output code written while ramping is off
    sequence vout_direct;
        REG_WR.we && REG_WR.addr == VOUT_SEL_OFFSET && !CORE_CTRL.ramp_on;
    endsequence
    // One ramp step at the fastest rate
    sequence fast_step;
        CORE_CTRL.ramp_on && CORE_CTRL.ramp_rate == 3'h7 && $changed(VOUT_TARGET);
    endsequence
    // Register, target and output stages: visible three samples later
    property target_follows;
        vout_direct |-> ##3 VOUT_TARGET == $past(REG_WR.data, 3);
    endproperty
    a_run_needs_on: assert property (CONV_RUN |-> CORE_CTRL.conv_on)
        else $error("converter runs while off");
    a_force_gives_pwm: assert property (
        CORE_CTRL.force_pwm && $past(CORE_CTRL.force_pwm) |-> PWM_SELECT)
        else $error("forced mode not PWM");
    a_fault_needs_on: assert property ($rose(SS_FAULT) |-> CORE_CTRL.conv_on)
        else $error("fault while converter off");
    a_fault_stops_run: assert property (SS_FAULT && $past(SS_FAULT) |-> !CONV_RUN)
        else $error("converter runs after fault");
    a_direct_target: assert property (target_follows)
        else $error("target did not follow write");
    a_ramp_one_step: assert property (
        CORE_CTRL.ramp_on && $past(CORE_CTRL.ramp_on) && $changed(VOUT_TARGET)
        |-> VOUT_TARGET == $past(VOUT_TARGET) + 8'h01
        || VOUT_TARGET == $past(VOUT_TARGET) - 8'h01) else $error("ramp step not one code");
    a_ramp_paced: assert property (fast_step |=> $stable(VOUT_TARGET) [*8])
        else $error("ramp steps too close");
    // A taken limit write would reach the output pin two samples later
    a_freeze_locks: assert property (
        CORE_CTRL.limit_freeze && REG_WR.we && REG_WR.addr == LIMIT_OFFSET_LO
        |-> ##2 $stable(FLOOR_LIMIT)) else $error("locked limit changed");
    a_freeze_sticky: assert property (
        $past(CORE_CTRL.limit_freeze) && !$past(SYS_RST) |-> CORE_CTRL.limit_freeze)
        else $error("freeze cleared");
endmodule

//--- verification/tb.sv
// Testbench for the converter mode-control block.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module tb;
    import bmc_pkg::*;
    localparam int SS_N = 20;
    logic MCLK, SYS_RST, IN_REGULATION, LOAD_HEAVY, CONV_RUN, PWM_SELECT, SS_FAULT;
    bmc_wr_type REG_WR;
    bmc_core_type CORE_CTRL;
    logic [7:0] REG_RD_ADDR, REG_RD_DATA, VOUT_TARGET, FLOOR_LIMIT, CEIL_LIMIT;
    logic [7:0] PFM_ILIMIT, PWM_ILIMIT;
    int fail_count = 0;
    int n_checks = 0;
    bmc_host_model bmc_host_model_i (.MCLK(MCLK), .REG_WR(REG_WR),
        .REG_RD_ADDR(REG_RD_ADDR), .REG_RD_DATA(REG_RD_DATA));
    bmc_mode_control #(.SS_CYCLES(SS_N)) bmc_mode_control_i (.MCLK(MCLK),
        .SYS_RST(SYS_RST), .REG_WR(REG_WR), .REG_RD_ADDR(REG_RD_ADDR),
        .REG_RD_DATA(REG_RD_DATA), .IN_REGULATION(IN_REGULATION),
        .LOAD_HEAVY(LOAD_HEAVY), .CORE_CTRL(CORE_CTRL), .CONV_RUN(CONV_RUN),
        .PWM_SELECT(PWM_SELECT), .SS_FAULT(SS_FAULT), .VOUT_TARGET(VOUT_TARGET),
        .FLOOR_LIMIT(FLOOR_LIMIT), .CEIL_LIMIT(CEIL_LIMIT), .PFM_ILIMIT(PFM_ILIMIT),
        .PWM_ILIMIT(PWM_ILIMIT));
    // 125 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        bmc_host_model_i.rd(a, v);
        check(v, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bmc_host_model_i.wr(a, d);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        SYS_RST = 1'b1;
        IN_REGULATION = 1'b0;
        LOAD_HEAVY = 1'b0;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        rdc(MODE_CTRL_OFFSET, MODE_CTRL_RESET);
        rdc(8'h20, 8'h00);
        check(8'(CONV_RUN), 8'h00);
        check(VOUT_TARGET, VOUT_RESET);
        check(8'(CORE_CTRL), 8'h0F);
        $display("reset test done");
        wr(8'h03, 8'h80);
        repeat (SS_N + 10) @(posedge MCLK);
        check(8'(CONV_RUN), 8'h01);
        check(8'(SS_FAULT), 8'h00);
        wr(8'h04, 8'h40);
        repeat (3) @(posedge MCLK);
        check(VOUT_TARGET, 8'h40);
        wr(8'h03, 8'h00);
        repeat (2) @(posedge MCLK);
        check(8'(CONV_RUN), 8'h00);
        wr(8'h03, 8'h90);
        for (int i = 0; i < SS_N + 20 && SS_FAULT !== 1'b1; i++) @(posedge MCLK);
        check(8'(SS_FAULT), 8'h01);
        check(8'(CONV_RUN), 8'h00);
        wr(8'h03, 8'h00);
        IN_REGULATION <= 1'b1;
        wr(8'h03, 8'h90);
        repeat (SS_N + 20) @(posedge MCLK);
        check({SS_FAULT, 6'h00, CONV_RUN}, 8'h01);
        $display("enable test done");
        wr(8'h03, 8'hC0);
        repeat (6) @(posedge MCLK);
        check(8'(PWM_SELECT), 8'h01);
        wr(8'h03, 8'h80);
        repeat (6) @(posedge MCLK);
        check(8'(PWM_SELECT), 8'h00);
        LOAD_HEAVY <= 1'b1;
        repeat (6) @(posedge MCLK);
        check(8'(PWM_SELECT), 8'h01);
        for (int r = 0; r < 8; r++) begin
            wr(8'h03, 8'h08 | 8'(r));
            rdc(8'h03, 8'h08 | 8'(r));
            check(8'(CORE_CTRL.ramp_rate), 8'(r));
        end
        wr(8'h04, 8'h43);
        repeat (200) @(posedge MCLK);
        check(VOUT_TARGET, 8'h41);
        repeat (250) @(posedge MCLK);
        check(VOUT_TARGET, 8'h43);
        // Rate code 6 paces one code every 250 cycles
        wr(8'h03, 8'h0E);
        wr(8'h04, 8'h44);
        repeat (240) @(posedge MCLK);
        check(VOUT_TARGET, 8'h43);
        repeat (20) @(posedge MCLK);
        check(VOUT_TARGET, 8'h44);
        $display("mode and ramp tests done");
        for (int a = 5; a < 9; a++) wr(8'(a), 8'(a * 16));
        wr(8'h03, 8'h20);
        for (int a = 5; a < 9; a++) wr(8'(a), 8'hFF);
        for (int a = 5; a < 9; a++) rdc(8'(a), 8'(a * 16));
        check(FLOOR_LIMIT, 8'h50);
        check(CEIL_LIMIT, 8'h60);
        check(PFM_ILIMIT, 8'h70);
        check(PWM_ILIMIT, 8'h80);
        check(8'(CORE_CTRL), 8'h10);
        wr(8'h03, 8'h00);
        rdc(8'h03, 8'h20);
        $display("freeze test done");
        // Mid-run reset releases the freeze
        SYS_RST <= 1'b1;
        repeat (2) @(posedge MCLK);
        SYS_RST <= 1'b0;
        rdc(MODE_CTRL_OFFSET, MODE_CTRL_RESET);
        wr(8'h05, 8'hA5);
        rdc(8'h05, 8'hA5);
        repeat (2) @(posedge MCLK);
        check(FLOOR_LIMIT, 8'hA5);
        $display("reset release test done");
        finish_test();
    end
endmodule
bind bmc_mode_control bmc_monitor bmc_monitor_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .REG_WR(REG_WR), .CORE_CTRL(CORE_CTRL), .CONV_RUN(CONV_RUN), .PWM_SELECT(PWM_SELECT),
    .SS_FAULT(SS_FAULT), .VOUT_TARGET(VOUT_TARGET), .FLOOR_LIMIT(FLOOR_LIMIT));
